/* core/clk_switch_ctl.sv */
// Purpose: System clock source switch control with PLL enable and status.
// Assumes: default_osc_cfg is static; oscillator pins are asynchronous.
// Notes  : Clock source is reported as a select code; the glitch-free mux
//          and the analog oscillators sit outside this block.
// Operation
// - Select field 00 takes the clock from the configured default source.
// - Select 1x runs from the internal block at the selected frequency.
// - Any reset clears the select field to zero.
// - A source change waits a settling delay before taking effect.
// - Wake from sleep onto an internal oscillator applies a warm-up delay.
// - Sleep or power-on to external clock waits two external cycles.
// - Switches onto the 31 kHz oscillator wait one old, one new cycle.
// - Switch to medium or high internal oscillator waits about 2 us.
// - PLL start allows about 2 ms before it is reported ready.
// - Control bit 7 turns the 4x PLL on or off.
// - Frequency field bits 6..3 decode to the documented frequency ladder.
// - Reset loads the frequency field with 0111, 500 kHz.
// - Codes 1010 to 1000 come from the high frequency oscillator.
// - Unimplemented control and status bits read zero.
// - Status bit 6 shows PLL ready, zero after power-on.
// - Status bit 4 shows high frequency oscillator ready.
// - Status bit 1 shows low frequency oscillator ready.
// - Status bit 0 shows high frequency oscillator stable.
// - Frequency change starts oscillator, waits falling current clock, completes.
// - Same oscillator source means no start-up delay.
// - PLL is never applied while the select field is 1x.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module clk_switch_ctl #(
  parameter int PLL_CYC  = clk_switch_pkg::PLL_CYC_DEF,
  parameter int WARM_CYC = clk_switch_pkg::WARM_CYC_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic [1:0]                 default_osc_cfg,
  input  wire logic                       sleep,
  input  wire clk_switch_pkg::osc_pins_s  pins,
  input  wire logic [1:0]                 addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [7:0]                      rdata,
  output clk_switch_pkg::clock_out_s      clk_out
);
  import clk_switch_pkg::*;

  // ----------------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------------
  localparam ctl_state_s CTL_RST = '{
    st: ST_IDLE, sel: SEL_RST, freq: FREQ_RST, pll_en: 1'b0,
    cur_src: SRC_EC, cur_freq: FREQ_RST, tgt_src: SRC_EC, tgt_freq: FREQ_RST,
    restart: 1'b1, from_stop: 1'b0, cnt: '0, edges: 2'h0,
    pll_act: 1'b0, pll_rdy: 1'b0, pll_cnt: '0,
    sync1: '0, sync2: '0, prev: '0, sleep_d: 1'b0, rdata: RD_IDLE,
    out: '{src: SRC_EC, freq: FREQ_RST, pll_on: 1'b0, hf_en: 1'b0,
           lf_en: 1'b0, busy: 1'b0}
  };

  ctl_state_s state_ff;
  ctl_state_s nxt_state;
  logic [2:0] clk_rise;
  logic [2:0] clk_fall;
  logic       want_int;
  src_e       want_src;
  logic       want_chg;
  logic       pll_req;
  logic       old_rise;
  logic       old_fall;
  logic       new_rise;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;

  // Pick the sampled clock bit belonging to a source
  function automatic logic clk_of(input src_e s, input logic [2:0] v);
    case (s)
      SRC_EC:  clk_of = v[0];
      SRC_LF:  clk_of = v[1];
      default: clk_of = v[2];
    endcase
  endfunction

  function automatic logic is_hf(input src_e s);
    is_hf = (s == SRC_HF) || (s == SRC_MF);
  endfunction

  // Edges come from second stage and its copy, never the first stage
  assign clk_rise = {state_ff.sync2.hf_clk, state_ff.sync2.lf_clk, state_ff.sync2.ext_clk}
                  & ~{state_ff.prev.hf_clk, state_ff.prev.lf_clk, state_ff.prev.ext_clk};
  assign clk_fall = ~{state_ff.sync2.hf_clk, state_ff.sync2.lf_clk, state_ff.sync2.ext_clk}
                  & {state_ff.prev.hf_clk, state_ff.prev.lf_clk, state_ff.prev.ext_clk};
  assign old_rise = clk_of(state_ff.cur_src, clk_rise);
  assign old_fall = clk_of(state_ff.cur_src, clk_fall);
  assign new_rise = clk_of(state_ff.tgt_src, clk_rise);

  // ----------------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------------
  // Reserved select 01 picks the source as 00 does since only the upper bit is decoded here; the PLL needs 00
  assign want_int = state_ff.sel[SEL_MSB] || (default_osc_cfg == CFG_INTERNAL);
  always_comb begin
    if (!want_int) begin
      want_src = SRC_EC;
    end else if (state_ff.freq[3:1] == 3'h0) begin
      want_src = SRC_LF;
    end else if (state_ff.freq[3]) begin
      want_src = SRC_HF;
    end else begin
      want_src = SRC_MF;
    end
  end
  assign want_chg = state_ff.restart || (want_src != state_ff.cur_src)
                  || (want_int && (state_ff.freq != state_ff.cur_freq));

  // PLL only with select 00 and the internal default source
  assign pll_req = state_ff.pll_en && (state_ff.sel == SEL_RST)
                 && (default_osc_cfg == CFG_INTERNAL) && !sleep;

  // Read views; unimplemented bits stay zero
  always_comb begin
    ctrl_rd = RD_IDLE;
    ctrl_rd[PLL_EN_POS] = state_ff.pll_en;
    ctrl_rd[FREQ_MSB:FREQ_LSB] = state_ff.freq;
    ctrl_rd[SEL_MSB:SEL_LSB] = state_ff.sel;
    stat_rd = RD_IDLE;
    stat_rd[STAT_PLL_POS] = state_ff.pll_rdy;
    stat_rd[STAT_HFR_POS] = state_ff.sync2.hf_run;
    stat_rd[STAT_LFR_POS] = state_ff.sync2.lf_run;
    stat_rd[STAT_HFS_POS] = state_ff.sync2.hf_stab;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.sync1 = pins;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.prev = state_ff.sync2;
    nxt_state.sleep_d = sleep;

    // Register port; status offset takes no write at all
    if (wr && (addr == ADDR_CTRL)) begin
      nxt_state.pll_en = wdata[PLL_EN_POS];
      nxt_state.freq = wdata[FREQ_MSB:FREQ_LSB];
      nxt_state.sel = wdata[SEL_MSB:SEL_LSB];
    end
    nxt_state.rdata = RD_IDLE;
    if (rd) begin
      case (addr)
        ADDR_CTRL: nxt_state.rdata = ctrl_rd;
        ADDR_STAT: nxt_state.rdata = stat_rd;
        default:   nxt_state.rdata = RD_IDLE;
      endcase
    end

    // Switch sequencer
    case (state_ff.st)
      ST_IDLE: begin
        if (want_chg && !sleep) begin
          nxt_state.tgt_src = want_src;
          nxt_state.tgt_freq = state_ff.freq;
          nxt_state.restart = 1'b0;
          nxt_state.from_stop = state_ff.restart;
          nxt_state.edges = 2'h0;
          if (state_ff.restart && (want_src == SRC_EC)) begin
            nxt_state.st = ST_NEW;
            nxt_state.edges = 2'(EXT_POR_EDGES);
          end else if (state_ff.restart) begin
            nxt_state.st = ST_START;
            nxt_state.cnt = CNT_W'(WARM_CYC - 1);
          end else if (want_src == state_ff.cur_src) begin
            nxt_state.st = ST_FALL;
          end else if (is_hf(want_src)) begin
            nxt_state.st = ST_START;
            nxt_state.cnt = CNT_W'(SW_CYC - 1);
          end else begin
            nxt_state.st = ST_OLD;
            nxt_state.edges = 2'(EACH_EDGES);
          end
        end
      end
      ST_START: begin
        if (state_ff.cnt == '0) begin
          nxt_state.st = ST_FALL;
        end else begin
          nxt_state.cnt = state_ff.cnt - 1'b1;
        end
      end
      ST_OLD: begin
        if (old_rise) begin
          nxt_state.st = ST_NEW;
        end
      end
      ST_NEW: begin
        if (new_rise) begin
          nxt_state.edges = state_ff.edges - 1'b1;
          if (state_ff.edges == 2'h1) begin
            nxt_state.st = ST_FALL;
          end
        end
      end
      ST_FALL: begin
        // A stopped old clock has no edge to wait for
        if (old_fall || state_ff.from_stop) begin
          nxt_state.st = ST_IDLE;
          nxt_state.cur_src = state_ff.tgt_src;
          nxt_state.cur_freq = state_ff.tgt_freq;
          nxt_state.from_stop = 1'b0;
        end
      end
      default: nxt_state.st = ST_IDLE;
    endcase

    // Wake from sleep forces a fresh start; set wins over the clear above
    if (state_ff.sleep_d && !sleep) begin
      nxt_state.restart = 1'b1;
    end

    // PLL lock timer; ready only after the full wait
    if (!pll_req) begin
      nxt_state.pll_act = 1'b0;
      nxt_state.pll_rdy = 1'b0;
    end else if (!state_ff.pll_act) begin
      nxt_state.pll_act = 1'b1;
      nxt_state.pll_cnt = CNT_W'(PLL_CYC - 1);
    end else if (state_ff.pll_cnt != '0) begin
      nxt_state.pll_cnt = state_ff.pll_cnt - 1'b1;
    end else begin
      nxt_state.pll_rdy = 1'b1;
    end

    // Output flops follow the committed state
    nxt_state.out.src = nxt_state.cur_src;
    nxt_state.out.freq = nxt_state.cur_freq;
    nxt_state.out.pll_on = nxt_state.pll_act;
    nxt_state.out.busy = (nxt_state.st != ST_IDLE);
    nxt_state.out.hf_en = !sleep && (is_hf(nxt_state.cur_src) || nxt_state.pll_act
                        || ((nxt_state.st != ST_IDLE) && is_hf(nxt_state.tgt_src)));
    nxt_state.out.lf_en = !sleep && ((nxt_state.cur_src == SRC_LF)
                        || ((nxt_state.st != ST_IDLE) && (nxt_state.tgt_src == SRC_LF)));
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset restores select 00 and frequency 0111; clock enable freezes all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= CTL_RST;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign rdata = state_ff.rdata;
  assign clk_out = state_ff.out;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic sw_go;
  assign sw_go = ce && (state_ff.st == ST_IDLE) && (nxt_state.st != ST_IDLE);

  ext_default_a: assert property (
    (sw_go && !state_ff.sel[SEL_MSB] && (default_osc_cfg != CFG_INTERNAL))
    |=> state_ff.tgt_src == SRC_EC) else $error("default select not external");
  lf_internal_a: assert property (
    (sw_go && state_ff.sel[SEL_MSB] && (state_ff.freq[3:1] == 3'h0))
    |=> (state_ff.tgt_src == SRC_LF) && (state_ff.tgt_freq == $past(state_ff.freq)))
    else $error("internal low code not on low oscillator");
  start_hold_a: assert property (
    (ce && (state_ff.st == ST_START) && (state_ff.cnt != '0))
    |=> (state_ff.st == ST_START) && $stable(state_ff.out.src))
    else $error("source changed during settling");
  warm_load_a: assert property (
    (sw_go && (nxt_state.st == ST_START) && state_ff.restart)
    |=> state_ff.cnt == CNT_W'(WARM_CYC - 1)) else $error("warm-up count wrong");
  ext_edges_a: assert property (
    (sw_go && (nxt_state.st == ST_NEW))
    |=> state_ff.edges == 2'(EXT_POR_EDGES)) else $error("external wake edge count");
  sw_delay_a: assert property (
    (sw_go && (nxt_state.st == ST_START) && !state_ff.restart)
    |=> state_ff.cnt == CNT_W'(SW_CYC - 1)) else $error("switch delay count wrong");
  pll_wait_a: assert property (
    $rose(state_ff.pll_act) |-> !state_ff.pll_rdy [*8])
    else $error("PLL ready too early");
  pll_follow_a: assert property (
    state_ff.out.pll_on |-> $past(state_ff.pll_en)) else $error("PLL on without enable");
  hf_duplicate_a: assert property (
    (sw_go && want_int && (state_ff.freq[3:2] == 2'h2))
    |=> state_ff.tgt_src == SRC_HF) else $error("duplicate code not on high oscillator");
  // Both views checked, so a stray bit in either read path is caught
  rsvd_zero_a: assert property (
    ($past(ce) && $past(rd))
    |-> (rdata & (($past(addr) == ADDR_STAT) ? STAT_RSVD : CTRL_RSVD)) == RD_IDLE)
    else $error("reserved register bits set");
  pll_flag_a: assert property (
    ($past(ce) && $past(rd) && ($past(addr) == ADDR_STAT))
    |-> rdata[STAT_PLL_POS] == $past(state_ff.pll_rdy)) else $error("PLL flag mismatch");
  fall_wait_a: assert property (
    (ce && (state_ff.st == ST_FALL) && (nxt_state.st == ST_IDLE))
    |-> (old_fall || state_ff.from_stop)) else $error("switch without falling edge");
  same_src_a: assert property (
    (sw_go && !state_ff.restart && (want_src == state_ff.cur_src))
    |=> state_ff.st == ST_FALL) else $error("start-up delay on same source");
  no_pll_int_a: assert property (
    (ce && state_ff.sel[SEL_MSB]) |=> !state_ff.pll_act) else $error("PLL with select 1x");
  stat_ro_a: assert property (
    (ce && wr && (addr == ADDR_STAT))
    |=> $stable(state_ff.pll_en) && $stable(state_ff.freq) && $stable(state_ff.sel))
    else $error("status write changed control");

  // Read-back of the control fields one cycle after the strobe
  ctrl_view_a: assert property (
    ($past(ce) && $past(rd) && ($past(addr) == ADDR_CTRL))
    |-> (rdata[FREQ_MSB:FREQ_LSB] == $past(state_ff.freq))
        && (rdata[PLL_EN_POS] == $past(state_ff.pll_en))
        && (rdata[SEL_MSB:SEL_LSB] == $past(state_ff.sel)))
    else $error("control read-back mismatch");
  // Ready and stable flags are the synchronised pin levels, nothing else
  osc_flags_a: assert property (
    ($past(ce) && $past(rd) && ($past(addr) == ADDR_STAT))
    |-> (rdata[STAT_HFR_POS] == $past(state_ff.sync2.hf_run))
        && (rdata[STAT_LFR_POS] == $past(state_ff.sync2.lf_run))
        && (rdata[STAT_HFS_POS] == $past(state_ff.sync2.hf_stab)))
    else $error("oscillator flag mismatch");
  // Middle codes run from the medium path
  mf_decode_a: assert property (
    (sw_go && want_int && !state_ff.freq[3] && (state_ff.freq[3:1] != 3'h0))
    |=> state_ff.tgt_src == SRC_MF) else $error("middle codes not on medium path");
  // Moving onto the low oscillator must see one old and one new edge
  lf_path_a: assert property (
    (sw_go && !state_ff.restart && (want_src == SRC_LF) && (state_ff.cur_src != SRC_LF))
    |=> (state_ff.st == ST_OLD) && (state_ff.edges == 2'(EACH_EDGES)))
    else $error("low oscillator switch skips edge wait");
  // The reported source only moves at the commit edge
  commit_src_a: assert property (
    (ce && (state_ff.st == ST_FALL) && (nxt_state.st == ST_IDLE))
    |=> clk_out.src == $past(state_ff.tgt_src)) else $error("committed source wrong");
  busy_flag_a: assert property (
    clk_out.busy == (state_ff.st != ST_IDLE)) else $error("busy flag out of step");

  switch_done_c: cover property (state_ff.st == ST_FALL ##1 state_ff.st == ST_IDLE);
  pll_ready_c: cover property ($rose(state_ff.pll_rdy));
  ext_wake_c: cover property (state_ff.st == ST_NEW && state_ff.edges == 2'h2);
  lf_switch_c: cover property (state_ff.st == ST_OLD ##[1:50] state_ff.st == ST_NEW);
  wake_restart_c: cover property (state_ff.sleep_d && !sleep);

endmodule

/* core/clk_switch_pkg.sv */
// Purpose: Shared constants and types of the system clock switch control.
// Assumes: 50 MHz control clock; word-addressed register port.
// Notes  : All offsets, field positions, resets and timing counts live here.
package clk_switch_pkg;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] ADDR_CTRL    = 2'h0;
  localparam logic [1:0] ADDR_STAT    = 2'h1;
  localparam int         PLL_EN_POS   = 7;
  localparam int         FREQ_MSB     = 6;
  localparam int         FREQ_LSB     = 3;
  localparam int         SEL_MSB      = 1;
  localparam int         SEL_LSB      = 0;
  localparam int         STAT_PLL_POS = 6;
  localparam int         STAT_HFR_POS = 4;
  localparam int         STAT_LFR_POS = 1;
  localparam int         STAT_HFS_POS = 0;
  localparam logic [7:0] CTRL_RSVD    = 8'h04;
  localparam logic [7:0] STAT_RSVD    = 8'hac;
  localparam logic [7:0] RD_IDLE      = 8'h00;
  localparam logic [3:0] FREQ_RST     = 4'h7;
  localparam logic [1:0] SEL_RST      = 2'h0;
  localparam logic [1:0] CFG_INTERNAL = 2'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SW_DELAY_NS   = 2000;
  localparam int SW_CYC        = (SW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_DELAY_NS  = 2000000;
  localparam int PLL_CYC_DEF   = (PLL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_DELAY_NS = 5000;
  localparam int WARM_CYC_DEF  = (WARM_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_POR_EDGES = 2;
  localparam int EACH_EDGES    = 1;
  localparam int CNT_W         = 17;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_EC = 2'h0, SRC_LF = 2'h1, SRC_HF = 2'h2, SRC_MF = 2'h3
  } src_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0, ST_START = 3'h1, ST_OLD = 3'h3, ST_NEW = 3'h2, ST_FALL = 3'h6
  } sw_state_e;

  typedef struct packed {
    logic lf_run;
    logic hf_stab;
    logic hf_run;
    logic hf_clk;
    logic lf_clk;
    logic ext_clk;
  } osc_pins_s;

  typedef struct packed {
    src_e       src;
    logic [3:0] freq;
    logic       pll_on;
    logic       hf_en;
    logic       lf_en;
    logic       busy;
  } clock_out_s;

  typedef struct packed {
    sw_state_e        st;
    logic [1:0]       sel;
    logic [3:0]       freq;
    logic             pll_en;
    src_e             cur_src;
    logic [3:0]       cur_freq;
    src_e             tgt_src;
    logic [3:0]       tgt_freq;
    logic             restart;
    logic             from_stop;
    logic [CNT_W-1:0] cnt;
    logic [1:0]       edges;
    logic             pll_act;
    logic             pll_rdy;
    logic [CNT_W-1:0] pll_cnt;
    osc_pins_s        sync1;
    osc_pins_s        sync2;
    osc_pins_s        prev;
    logic             sleep_d;
    logic [7:0]       rdata;
    clock_out_s       out;
  } ctl_state_s;

endpackage

/* sim/clk_switch_ctl_tb.sv */
// Purpose: Self-checking bench for the system clock switch control block.
// Assumes: PLL and warm-up counts shortened; oscillator clocks toggled by the bench.
// Notes  : Inputs change by NBA at rising edges; outputs are sampled 1 ns later.
`timescale 1ns/1ps
module clk_switch_ctl_tb;
  import clk_switch_pkg::*;
  localparam int PLL_N  = 20;
  localparam int WARM_N = 5;
  logic       clk             = 1'b0;
  logic       rst_n           = 1'b0;
  logic [1:0] cfg             = 2'h0;
  logic       sleep           = 1'b0;
  logic [2:0] run             = 3'h0;
  logic [3:0] tick            = 4'h0;
  logic [1:0] addr            = 2'h0;
  logic [7:0] wdata           = 8'h00;
  logic       wr              = 1'b0;
  logic       rd              = 1'b0;
  logic       ce              = 1'b1;
  logic [7:0] rdata;
  osc_pins_s  pins;
  clock_out_s clk_out;
  int         error_cnt       = 0;
  int         samples_checked = 0;
  int         cycles          = 0;
  int         n;
  logic [7:0] v;

  // --------------------------------------------------------------------
  // Clock, oscillator pins, timeout
  // --------------------------------------------------------------------
  always #10 clk = ~clk;
  // Unequal periods so every switch path sees distinct old and new edges
  assign pins = osc_pins_s'({run, tick[1], tick[3], tick[2]});
  always @(posedge clk) begin
    tick <= tick + 4'h1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  clk_switch_ctl #(.PLL_CYC(PLL_N), .WARM_CYC(WARM_N)) u_clk_switch_ctl (
    .clk             (clk),
    .rst_n           (rst_n),
    .ce              (ce),
    .default_osc_cfg (cfg),
    .sleep           (sleep),
    .pins            (pins),
    .addr            (addr),
    .wdata           (wdata),
    .wr              (wr),
    .rd              (rd),
    .rdata           (rdata),
    .clk_out         (clk_out)
  );

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_src(input src_e s);
    chk("clock source", {6'h0, s}, {6'h0, clk_out.src});
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Bounded wait for the switch in progress; cnt is its length in cycles
  task automatic wait_idle(output int cnt);
    cnt = 0;
    @(posedge clk);
    #1;
    while (clk_out.busy !== 1'b0 && cnt < 600) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt == 600) chk("switch completion", 8'h00, 8'h01);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  // Select code 01 is never written by the bench
  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk_src(SRC_EC);
    @(posedge clk);
    rst_n <= 1'b1;
    wait_idle(n);
    chk_src(SRC_MF);
    chk("boot warm-up", 8'h01, 8'(n >= WARM_N));
    rd_reg(ADDR_CTRL, v);
    chk("control reset", 8'h38, v);
    rd_reg(ADDR_STAT, v);
    chk("status reset", 8'h00, v);
    @(posedge clk);
    #1;
    chk("read data idle", 8'h00, rdata);
    $display("reset test done");
    // Default source to high band, reserved bit 2 written high
    wr_reg(ADDR_CTRL, 8'h7c);
    wait_idle(n);
    chk("settle delay", 8'h01, 8'(n >= SW_CYC));
    chk_src(SRC_HF);
    rd_reg(ADDR_CTRL, v);
    chk("control readback", 8'h78, v);
    wr_reg(ADDR_STAT, 8'hff);
    wr_reg(2'h3, 8'hff);
    rd_reg(ADDR_STAT, v);
    chk("status write ignored", 8'h00, v);
    rd_reg(ADDR_CTRL, v);
    chk("unmapped write", 8'h78, v);
    rd_reg(2'h2, v);
    chk("unmapped read", 8'h00, v);
    $display("register test done");
    // Whole frequency ladder from the internal block
    for (int c = 15; c >= 0; c--) begin
      wr_reg(ADDR_CTRL, {1'b0, 4'(c), 3'b010});
      wait_idle(n);
      chk_src(c >= 8 ? SRC_HF : (c >= 2 ? SRC_MF : SRC_LF));
      chk("frequency code", {4'h0, 4'(c)}, {4'h0, clk_out.freq});
      chk("osc enables", {6'h0, (c >= 2), (c < 2)}, {6'h0, clk_out.hf_en, clk_out.lf_en});
      if (c == 14) chk("same source fast", 8'h01, 8'(n < 20));
      if (c == 7) chk("band change slow", 8'h01, 8'(n >= SW_CYC));
    end
    $display("ladder test done");
    // PLL on the 8 MHz code, then forced off by select 1x
    wr_reg(ADDR_CTRL, 8'hf0);
    @(posedge clk);
    #1;
    chk("pll running", 8'h01, {7'h0, clk_out.pll_on});
    rd_reg(ADDR_STAT, v);
    chk("pll not ready", 8'h00, v);
    repeat (PLL_N) @(posedge clk);
    rd_reg(ADDR_STAT, v);
    chk("pll ready", 8'h40, v);
    wr_reg(ADDR_CTRL, 8'hf2);
    @(posedge clk);
    #1;
    chk("pll off in 1x", 8'h00, {7'h0, clk_out.pll_on});
    wait_idle(n);
    rd_reg(ADDR_STAT, v);
    chk("pll ready dropped", 8'h00, v);
    $display("pll test done");
    // Oscillator ready and stable flags
    @(posedge clk);
    run <= 3'h7;
    repeat (4) @(posedge clk);
    rd_reg(ADDR_STAT, v);
    chk("all ready", 8'h13, v);
    @(posedge clk);
    run <= 3'h2;
    repeat (4) @(posedge clk);
    rd_reg(ADDR_STAT, v);
    chk("stable only", 8'h01, v);
    $display("status test done");
    // Wake from sleep onto the internal block
    @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("sleep enables", 8'h00, {6'h0, clk_out.hf_en, clk_out.lf_en});
    @(posedge clk);
    sleep <= 1'b0;
    // Restart is raised on the edge that first sees sleep low
    @(posedge clk);
    wait_idle(n);
    chk("wake warm-up", 8'h01, 8'(n >= WARM_N));
    chk_src(SRC_HF);
    // External default source, then wake onto it
    @(posedge clk);
    cfg <= 2'h1;
    wr_reg(ADDR_CTRL, 8'h70);
    wait_idle(n);
    chk_src(SRC_EC);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (3) @(posedge clk);
    sleep <= 1'b0;
    @(posedge clk);
    wait_idle(n);
    chk("two ext cycles", 8'h01, 8'(n >= 8));
    chk_src(SRC_EC);
    $display("sleep test done");
    // Clock enable low freezes the register port
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(ADDR_CTRL, 8'h02);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(ADDR_CTRL, v);
    chk("frozen write", 8'h70, v);
    $display("freeze test done");
    // Reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("freq in reset", 8'h07, {4'h0, clk_out.freq});
    @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CTRL, v);
    chk("control after reset", 8'h38, v);
    $display("second reset test done");
    summarize();
  end
endmodule
